// *** dcs_scheduler.sv ***
/*
 * Column command scheduler: request buffer, four group state machines,
 * read-first round-robin or acceptance-order arbitration, read-to-write gap,
 * and timing strobes for the external read and write data movers.
 * Assumes requester, PHY and movers share mclk; data never enters here.
 */
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Contract
// - Present write buffer address cycle before data
// - Read data with address, unbuffered, unordered
// - Exactly four group state machines
// - Each machine holds one, in order
// - Machine freed once column command issues
// - Same-machine requests never reordered
// - Reads preferred when reordering is enabled
// - Read issue blocks writes for gap
// - Round-robin among machines with safe commands
// - Acceptance_order_policy policy issues in acceptance order
// - DDR3 machine index is BA[2:1]
// - DDR4 x4/x8 machine n serves group n
// - DDR4 x16 index is {BG, BA[0]}
// - Only timing strobes to data movers
module dcs_scheduler
	import dcs_pkg::*;
#(
	parameter int unsigned NUM_GM     = DCS_NUM_GM,
	parameter int unsigned WR_LAT_CYC = DCS_WR_LAT_CYC,
	parameter int unsigned RD_LAT_CYC = DCS_RD_LAT_CYC
) (
	input  wire logic                  mclk,
	input  wire logic                  rst_b,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [31:0]                reg_rdata,
	input  wire logic                  cal_done,
	input  wire logic                  req_valid,
	input  wire dcs_req_t              req,
	output logic                       req_ready,
	output logic                       cmd_valid,
	output dcs_cmd_t                   cmd,
	output logic                       wr_buf_req,
	output logic [DCS_BUF_AW-1:0]      wr_buf_addr,
	output logic                       wr_mover_take,
	output logic                       rd_buf_valid,
	output logic [DCS_BUF_AW-1:0]      rd_buf_addr,
	output logic                       rd_mover_take
);
	initial begin
		if (NUM_GM != 4) $error("dcs_scheduler: exactly four group machines supported");
		if (WR_LAT_CYC < 2 || WR_LAT_CYC > 16) $error("dcs_scheduler: WR_LAT_CYC range");
		if (RD_LAT_CYC < 2 || RD_LAT_CYC > 16) $error("dcs_scheduler: RD_LAT_CYC range");
	end

	localparam int WR_ISSUE_DLY = WR_LAT_CYC - 1;
	localparam int RD_ISSUE_DLY = RD_LAT_CYC - 1;

	// Register state
	logic [2:0]  ctrl_r;
	logic [7:0]  gap_r;
	logic [31:0] issued_r;
	logic [31:0] rdata_r;
	dcs_order_t  pol_act_r;
	dcs_tech_t   tech_act_r;

	// Buffer and dispatch
	logic        bq_valid;
	logic        bq_ready;
	logic [1:0]  bq_level;
	logic [$bits(dcs_req_t)-1:0] bq_bits;
	dcs_req_t    bq_req;
	logic [1:0]  tgt;
	logic        cfg_pend;
	logic        dispatch;

	// Group machines and arbitration
	logic [3:0]  gm_free;
	logic [3:0]  gm_safe;
	logic [3:0]  gm_wr;
	dcs_req_t    gm_held [4];
	logic [3:0]  load_vec;
	logic [3:0]  cand;
	logic [3:0]  rd_cand;
	logic [3:0]  pool;
	logic [3:0]  gnt;
	logic [1:0]  gnt_idx;
	logic [1:0]  rr_ptr_r;
	logic [7:0]  gap_cnt_r;
	logic [7:0]  gap_cyc;
	logic [8:0]  gap_sum;
	logic        gap_block;

	// Acceptance order queue
	logic [1:0]  ord_q [4];
	logic [1:0]  ord_head_r;
	logic [1:0]  ord_tail_r;
	logic [2:0]  ord_cnt_r;

	// Output flops and data mover pipelines
	logic        cmd_valid_r;
	dcs_cmd_t    cmd_r;
	logic [WR_LAT_CYC-2:0] wr_v_r;
	logic [DCS_BUF_AW-1:0] wr_a_r [WR_LAT_CYC-1];
	logic [RD_LAT_CYC-2:0] rd_v_r;
	logic [DCS_BUF_AW-1:0] rd_a_r [RD_LAT_CYC-1];
	logic        wr_buf_req_r;
	logic [DCS_BUF_AW-1:0] wr_buf_addr_r;
	logic        wr_take_r;
	logic        rd_valid_r;
	logic [DCS_BUF_AW-1:0] rd_addr_r;
	logic        rd_take_r;
	logic [7:0]  since_rd_r;

	assign reg_rdata     = rdata_r;
	assign cmd_valid     = cmd_valid_r;
	assign cmd           = cmd_r;
	assign wr_buf_req    = wr_buf_req_r;
	assign wr_buf_addr   = wr_buf_addr_r;
	assign wr_mover_take = wr_take_r;
	assign rd_buf_valid  = rd_valid_r;
	assign rd_buf_addr   = rd_addr_r;
	assign rd_mover_take = rd_take_r;

	// Register writes; unmapped offsets are ignored
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ctrl_r <= DCS_CTRL_RST;
			gap_r  <= DCS_GAP_RST;
		end else if (reg_wr) begin
			if (reg_addr == DCS_OFF_CTRL) ctrl_r <= reg_wdata[2:0];
			if (reg_addr == DCS_OFF_GAP)  gap_r  <= reg_wdata[7:0];
		end
	end

	// Read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rdata_r <= 32'h0;
		end else begin
			rdata_r <= 32'h0;
			if (reg_rd) begin
				unique case (reg_addr)
					DCS_OFF_CTRL:   rdata_r <= {29'h0, ctrl_r};
					DCS_OFF_GAP:    rdata_r <= {24'h0, gap_r};
					DCS_OFF_STATUS: rdata_r <= {19'h0, ord_cnt_r, bq_level, tech_act_r,
						pol_act_r, gap_block, gm_free};
					DCS_OFF_ISSUED: rdata_r <= issued_r;
					default:        rdata_r <= 32'h0;
				endcase
			end
		end
	end

	// Policy and technology switch only with all machines empty, so the
	// order queue never sees a half-finished mix of the two policies
	assign cfg_pend = (ctrl_r[DCS_CTRL_POL_BIT] != pol_act_r)
		|| (ctrl_r[DCS_CTRL_TECH_LSB +: 2] != tech_act_r);
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			pol_act_r  <= DCS_ROUND_ROBIN_REORDER;
			tech_act_r <= DCS_DDR3;
		end else if (cfg_pend && (&gm_free) && !cmd_valid_r) begin
			pol_act_r  <= dcs_order_t'(ctrl_r[DCS_CTRL_POL_BIT]);
			tech_act_r <= dcs_tech_t'(ctrl_r[DCS_CTRL_TECH_LSB +: 2]);
		end
	end

	dcs_req_buf #(
		.WIDTH     ($bits(dcs_req_t))
	) u_req_buf (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.in_valid  (req_valid),
		.in_ready  (req_ready),
		.in_data   (req),
		.out_valid (bq_valid),
		.out_ready (bq_ready),
		.out_data  (bq_bits),
		.level     (bq_level)
	);

	// Head request goes to its machine only when that machine is free,
	// which keeps same-machine requests in arrival order
	assign bq_req   = dcs_req_t'(bq_bits);
	assign tgt      = dcs_map_gm(tech_act_r, bq_req.bg, bq_req.ba);
	assign bq_ready = cal_done && !cfg_pend && gm_free[tgt];
	assign dispatch = bq_valid && bq_ready;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_gm
			assign load_vec[gi] = dispatch && (tgt == 2'(gi));
			assign gm_wr[gi]    = gm_held[gi].write;
			dcs_group_machine #(
				.PREP_CYC (DCS_PREP_CYC)
			) u_gm (
				.mclk     (mclk),
				.rst_b    (rst_b),
				.load     (load_vec[gi]),
				.load_req (bq_req),
				.grant    (gnt[gi]),
				.free     (gm_free[gi]),
				.safe     (gm_safe[gi]),
				.held     (gm_held[gi])
			);
		end
	endgenerate

	// Acceptance order of machines, used only under the acceptance_order_policy policy
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ord_head_r <= 2'h0;
			ord_tail_r <= 2'h0;
			ord_cnt_r  <= 3'h0;
		end else if (pol_act_r == DCS_ACCEPTANCE_ORDER_POLICY) begin
			ord_tail_r <= 2'(ord_tail_r + {1'b0, dispatch});
			ord_head_r <= 2'(ord_head_r + {1'b0, |gnt});
			ord_cnt_r  <= 3'(ord_cnt_r + {2'h0, dispatch} - {2'h0, |gnt});
		end
	end

	always_ff @(posedge mclk) begin
		if (dispatch) begin
			ord_q[ord_tail_r] <= tgt;
		end
	end

	// Read-to-write gap converted from memory clocks, rounded up
	assign gap_sum   = 9'({1'b0, gap_r}) + 9'(DCS_MCLK_PER_CYC - 1);
	assign gap_cyc   = 8'(gap_sum >> DCS_MCLK_SHIFT);
	assign gap_block = (gap_cnt_r != 8'h0);
	assign rd_cand   = gm_safe & ~gm_wr;
	assign cand      = rd_cand | (gm_safe & gm_wr & {4{!gap_block}});

	// Candidate pool by policy
	always_comb begin
		pool = 4'h0;
		if (pol_act_r == DCS_ACCEPTANCE_ORDER_POLICY) begin
			// Only the oldest accepted request may go, reads first or not
			if (ord_cnt_r != 3'h0) pool = cand & (4'h1 << ord_q[ord_head_r]);
		end else if (|rd_cand) begin
			pool = rd_cand;
		end else begin
			pool = cand;
		end
	end

	// Round-robin pick starting at the machine after the last winner
	always_comb begin
		logic [1:0] idx;
		logic       found;
		idx     = 2'h0;
		found   = 1'b0;
		gnt_idx = 2'h0;
		for (int k = 0; k < 4; k++) begin
			idx = 2'(rr_ptr_r + 2'(k));
			if (!found && pool[idx]) begin
				gnt_idx = idx;
				found   = 1'b1;
			end
		end
		gnt = found ? (4'h1 << gnt_idx) : 4'h0;
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rr_ptr_r <= 2'h0;
		end else if (|gnt) begin
			rr_ptr_r <= 2'(gnt_idx + 2'h1);
		end
	end

	// Gap counter loads on each read grant and holds writes off
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			gap_cnt_r <= 8'h0;
		end else if ((|gnt) && !gm_wr[gnt_idx]) begin
			gap_cnt_r <= gap_cyc;
		end else if (gap_block) begin
			gap_cnt_r <= 8'(gap_cnt_r - 8'h1);
		end
	end

	// Column command toward the PHY; it never stalls
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cmd_valid_r <= 1'b0;
			cmd_r       <= '0;
			issued_r    <= 32'h0;
		end else begin
			cmd_valid_r <= |gnt;
			if (|gnt) begin
				cmd_r    <= '{gm: gnt_idx, req: gm_held[gnt_idx]};
				issued_r <= 32'(issued_r + 32'h1);
			end
		end
	end

	// Data mover timing pipelines; only addresses and strobes travel here
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wr_v_r <= '0;
			rd_v_r <= '0;
		end else begin
			wr_v_r <= (WR_LAT_CYC-1)'({wr_v_r, (|gnt) && gm_wr[gnt_idx]});
			rd_v_r <= (RD_LAT_CYC-1)'({rd_v_r, (|gnt) && !gm_wr[gnt_idx]});
		end
	end

	always_ff @(posedge mclk) begin
		wr_a_r[0] <= gm_held[gnt_idx].buf_addr;
		rd_a_r[0] <= gm_held[gnt_idx].buf_addr;
		for (int s = 1; s < WR_LAT_CYC - 1; s++) wr_a_r[s] <= wr_a_r[s-1];
		for (int s = 1; s < RD_LAT_CYC - 1; s++) rd_a_r[s] <= rd_a_r[s-1];
	end

	// Address one cycle ahead, mover takes master data the next cycle
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wr_buf_req_r  <= 1'b0;
			wr_buf_addr_r <= '0;
			wr_take_r     <= 1'b0;
		end else begin
			wr_buf_req_r  <= wr_v_r[WR_LAT_CYC-2];
			wr_buf_addr_r <= wr_a_r[WR_LAT_CYC-2];
			wr_take_r     <= wr_buf_req_r;
		end
	end

	// Read address leaves with the data; no stall exists by design
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rd_valid_r <= 1'b0;
			rd_addr_r  <= '0;
			rd_take_r  <= 1'b0;
		end else begin
			rd_valid_r <= rd_v_r[RD_LAT_CYC-2];
			rd_addr_r  <= rd_a_r[RD_LAT_CYC-2];
			rd_take_r  <= rd_v_r[RD_LAT_CYC-2];
		end
	end

	// Cycles since the last read command reached the PHY, for checking
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			since_rd_r <= DCS_SINCE_RST;
		end else if (cmd_valid_r && !cmd_r.req.write) begin
			since_rd_r <= 8'h1;
		end else if (since_rd_r != 8'hff) begin
			since_rd_r <= 8'(since_rd_r + 8'h1);
		end
	end

	a_gap_before_write: assert property (@(posedge mclk) disable iff (!rst_b)
		cmd_valid_r && cmd_r.req.write |-> {1'b0, since_rd_r} > {1'b0, gap_cyc})
		else $error("Write issued inside read-to-write gap");
	a_reads_first: assert property (@(posedge mclk) disable iff (!rst_b)
		(pol_act_r == DCS_ROUND_ROBIN_REORDER) && (|gnt) && gm_wr[gnt_idx]
		|-> !(|(gm_safe & ~gm_wr)))
		else $error("Write granted while a read was safe");
	a_acceptance_order_policy_head: assert property (@(posedge mclk) disable iff (!rst_b)
		(pol_act_r == DCS_ACCEPTANCE_ORDER_POLICY) && (|gnt)
		|-> gnt_idx == ord_q[ord_head_r] && ord_cnt_r != 3'h0)
		else $error("Acceptance_order_policy policy issued out of acceptance order");
	a_rr_fair: assert property (@(posedge mclk) disable iff (!rst_b)
		(|gnt) ##1 ((|gnt) && pool[2'($past(gnt_idx) + 2'h1)])
		|-> gnt_idx == 2'($past(gnt_idx) + 2'h1))
		else $error("Round-robin skipped the machine after the last winner");
	a_wr_addr_time: assert property (@(posedge mclk) disable iff (!rst_b)
		cmd_valid_r && cmd_r.req.write |-> ##WR_ISSUE_DLY wr_buf_req_r
		##1 wr_mover_take)
		else $error("Write buffer address or take strobe mistimed");
	a_rd_return: assert property (@(posedge mclk) disable iff (!rst_b)
		cmd_valid_r && !cmd_r.req.write |-> ##RD_ISSUE_DLY rd_valid_r && rd_take_r
		&& rd_addr_r == $past(cmd_r.req.buf_addr, RD_ISSUE_DLY))
		else $error("Read return address or strobe mistimed");
	a_map_ddr3: assert property (@(posedge mclk) disable iff (!rst_b)
		dispatch && tech_act_r == DCS_DDR3 |-> load_vec == (4'h1 << bq_req.ba[2:1]))
		else $error("DDR3 request sent to wrong machine");
	a_map_ddr4_x8: assert property (@(posedge mclk) disable iff (!rst_b)
		dispatch && tech_act_r == DCS_DDR4_X8 |-> load_vec == (4'h1 << bq_req.bg))
		else $error("DDR4 x8 request sent to wrong machine");
	a_map_ddr4_x16: assert property (@(posedge mclk) disable iff (!rst_b)
		dispatch && tech_act_r == DCS_DDR4_X16
		|-> load_vec == (4'h1 << {bq_req.bg[0], bq_req.ba[0]}))
		else $error("DDR4 x16 request sent to wrong machine");
	a_reset_idle: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(rst_b) |-> gm_free == 4'hf && gap_cnt_r == 8'h0 && !cmd_valid_r)
		else $error("Scheduler not idle after reset");
endmodule : dcs_scheduler

// *** dcs_pkg.sv ***
/*
 * Shared constants, types and decode helpers of the DDR command scheduler.
 * Assumes one fabric clock running at a quarter of the memory clock.
 */
package dcs_pkg;
	localparam int unsigned DCS_NUM_GM       = 4;    // Group state machines
	localparam int unsigned DCS_MCLK_PER_CYC = 4;    // Memory clocks per fabric cycle
	localparam int unsigned DCS_MCLK_SHIFT   = 2;    // log2 of the ratio above
	localparam int unsigned DCS_BUF_AW       = 6;    // Data buffer address width
	localparam int unsigned DCS_PREP_CYC     = 2;    // Cycles until a column command is safe
	localparam int unsigned DCS_WR_LAT_CYC   = 3;    // Issue to write data needed
	localparam int unsigned DCS_RD_LAT_CYC   = 5;    // Issue to read data available

	// Register map, one 32-bit word each
	localparam logic [7:0]  DCS_OFF_CTRL     = 8'h00;
	localparam logic [7:0]  DCS_OFF_GAP      = 8'h04;
	localparam logic [7:0]  DCS_OFF_STATUS   = 8'h08;
	localparam logic [7:0]  DCS_OFF_ISSUED   = 8'h0c;
	localparam int unsigned DCS_CTRL_POL_BIT = 0;
	localparam int unsigned DCS_CTRL_TECH_LSB = 1;
	localparam logic [2:0]  DCS_CTRL_RST     = 3'h0;
	localparam logic [7:0]  DCS_GAP_RST      = 8'h0c; // Memory clocks
	localparam logic [7:0]  DCS_SINCE_RST    = 8'hff;

	typedef enum logic [1:0] {
		DCS_DDR3     = 2'b00,
		DCS_DDR4_X8  = 2'b01,
		DCS_DDR4_X16 = 2'b10
	} dcs_tech_t;

	typedef enum logic {
		DCS_ROUND_ROBIN_REORDER     = 1'b0,
		DCS_ACCEPTANCE_ORDER_POLICY = 1'b1
	} dcs_order_t;

	typedef enum logic [1:0] {
		DCS_GM_IDLE = 2'b00,
		DCS_GM_PREP = 2'b01,
		DCS_GM_SAFE = 2'b10
	} dcs_gm_state_t;

	typedef struct packed {
		logic                  write;
		logic [1:0]            bg;
		logic [2:0]            ba;
		logic [15:0]           row;
		logic [9:0]            col;
		logic [DCS_BUF_AW-1:0] buf_addr;
	} dcs_req_t;

	typedef struct packed {
		logic [1:0] gm;
		dcs_req_t   req;
	} dcs_cmd_t;

	// Group state machine index from technology, bank group and bank
	function automatic logic [1:0] dcs_map_gm(input dcs_tech_t tech, input logic [1:0] bg,
		input logic [2:0] ba);
		unique case (tech)
			DCS_DDR3:     dcs_map_gm = ba[2:1];
			DCS_DDR4_X8:  dcs_map_gm = bg;
			DCS_DDR4_X16: dcs_map_gm = {bg[0], ba[0]};
			default:      dcs_map_gm = ba[2:1];
		endcase
	endfunction : dcs_map_gm
endpackage : dcs_pkg

// *** dcs_req_buf.sv ***
/*
 * Two-entry request buffer with valid/ready on both sides.
 * Assumes the source honours in_ready and the sink may stall at will.
 */
`timescale 1ns/1ps
module dcs_req_buf
	import dcs_pkg::*;
#(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             rst_b,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic [1:0]            level
);
	initial begin
		if (WIDTH < 1) $error("dcs_req_buf: WIDTH must be positive");
	end

	logic [WIDTH-1:0] mem [2];
	logic             wr_ptr_r;
	logic             rd_ptr_r;
	logic [1:0]       cnt_r;
	logic [1:0]       cnt_nxt;
	logic             ready_r;
	logic             push;
	logic             pop;

	assign push      = in_valid && ready_r;
	assign pop       = out_valid && out_ready;
	assign out_valid = (cnt_r != 2'h0);
	assign out_data  = mem[rd_ptr_r];
	assign in_ready  = ready_r;
	assign level     = cnt_r;
	assign cnt_nxt   = 2'(cnt_r + {1'b0, push} - {1'b0, pop});

	// Ready is a flop so the master sees back-pressure without a comb path
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cnt_r    <= 2'h0;
			ready_r  <= 1'b0;
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
		end else begin
			cnt_r    <= cnt_nxt;
			ready_r  <= (cnt_nxt != 2'h2);
			wr_ptr_r <= wr_ptr_r ^ push;
			rd_ptr_r <= rd_ptr_r ^ pop;
		end
	end

	// Storage needs no reset, count guards it
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	a_buf_no_overrun: assert property (@(posedge mclk) disable iff (!rst_b)
		push |-> cnt_r != 2'h2) else $error("Buffer written while full");
endmodule : dcs_req_buf

// *** dcs_group_machine.sv ***
/*
 * One group state machine: holds a single transaction until its column
 * command is granted. Assumes load only while free.
 */
`timescale 1ns/1ps
module dcs_group_machine
	import dcs_pkg::*;
#(
	parameter int unsigned PREP_CYC = DCS_PREP_CYC
) (
	input  wire logic     mclk,
	input  wire logic     rst_b,
	input  wire logic     load,
	input  wire dcs_req_t load_req,
	input  wire logic     grant,
	output logic          free,
	output logic          safe,
	output dcs_req_t      held
);
	initial begin
		if (PREP_CYC < 1 || PREP_CYC > 15) $error("dcs_group_machine: PREP_CYC out of range");
	end

	dcs_gm_state_t state_r;
	logic [3:0]    prep_r;

	assign free = (state_r == DCS_GM_IDLE);
	assign safe = (state_r == DCS_GM_SAFE);

	// One transaction at a time; freed the cycle after its grant
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state_r <= DCS_GM_IDLE;
			prep_r  <= 4'h0;
		end else begin
			unique case (state_r)
				DCS_GM_IDLE: if (load) begin
					state_r <= DCS_GM_PREP;
					prep_r  <= 4'(PREP_CYC - 1);
				end
				DCS_GM_PREP: if (prep_r == 4'h0) begin
					state_r <= DCS_GM_SAFE;
				end else begin
					prep_r <= 4'(prep_r - 4'h1);
				end
				DCS_GM_SAFE: if (grant) begin
					state_r <= DCS_GM_IDLE;
				end
				default: state_r <= DCS_GM_IDLE;
			endcase
		end
	end

	// Payload captured on load only
	always_ff @(posedge mclk) begin
		if (load && free) begin
			held <= load_req;
		end
	end

	a_gm_single_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		load |-> free) else $error("Group machine loaded while busy");
	a_gm_free_on_issue: assert property (@(posedge mclk) disable iff (!rst_b)
		grant |=> free) else $error("Group machine not free after column issue");
endmodule : dcs_group_machine

// *** dcs_app_master.sv ***
/*
 * Behavioural application master for the scheduler's native request port.
 * Assumes it shares mclk with the scheduler and is driven by the bench.
 */
`timescale 1ns/1ps
module dcs_app_master
	import dcs_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  cal_done,
	input  wire logic                  req_ready,
	input  wire logic                  wr_buf_req,
	input  wire logic [DCS_BUF_AW-1:0] wr_buf_addr,
	input  wire logic                  rd_buf_valid,
	output logic                       req_valid,
	output dcs_req_t                   req,
	output logic [7:0]                 wr_data,
	output logic [15:0]                rd_seen
);
	initial begin
		req_valid = 1'b0;
		req       = '0;
		wr_data   = 8'h00;
		rd_seen   = 16'h0000;
	end

	// Request held until the edge that takes it; last releases the bus
	task automatic send(input dcs_req_t r, input logic last);
		logic ok;
		while (cal_done !== 1'b1) @(posedge mclk);
		req_valid <= 1'b1;
		req       <= r;
		do begin
			@(negedge mclk);
			ok = req_ready;
			@(posedge mclk);
		end while (ok !== 1'b1);
		if (last) begin
			req_valid <= 1'b0;
			req       <= ~r; // Released bus must not keep the old value
		end
	endtask : send

	// Data follows its buffer address by one cycle; returns never stall
	always @(posedge mclk) begin
		wr_data <= wr_buf_req ? {2'h0, wr_buf_addr} ^ 8'ha5 : ~wr_data;
		if (rd_buf_valid === 1'b1) begin
			rd_seen <= rd_seen + 16'h0001;
		end
	end
endmodule : dcs_app_master

// *** testbench.sv ***
/*
 * Self-checking bench of the scheduler: mapping table, arbitration, gap, reset.
 * Assumes default latencies and a master model that keeps its own rules.
 */
`timescale 1ns/1ps
module testbench;
	import dcs_pkg::*;
	typedef struct packed {
		dcs_tech_t  tech;
		logic [1:0] bg;
		logic [2:0] ba;
		logic       wr;
		logic [1:0] gm;
	} dcs_row_t;
	logic                  mclk = 1'b0, rst_b = 1'b0, cal_done = 1'b0;
	logic                  reg_wr = 1'b0, reg_rd = 1'b0, wr_prev = 1'b0;
	logic [7:0]            reg_addr = 8'h00, wr_data;
	logic [31:0]           reg_wdata = 32'h0, reg_rdata;
	logic                  req_valid, req_ready, cmd_valid, wr_buf_req, wr_mover_take;
	logic                  rd_buf_valid, rd_mover_take;
	logic [15:0]           rd_seen;
	dcs_req_t              req;
	dcs_cmd_t              cmd, cmdq[$];
	logic [DCS_BUF_AW-1:0] wr_buf_addr, rd_buf_addr, rd_a[$], wr_a[$];
	int                    bad_count = 0, checks = 0, cyc = 0, cmd_cyc[$], rd_t[$], wr_t[$];
	dcs_row_t              rows[13] = '{
		'{DCS_DDR3, 2'h3, 3'h1, 1'b0, 2'h0}, '{DCS_DDR3, 2'h0, 3'h3, 1'b1, 2'h1},
		'{DCS_DDR3, 2'h2, 3'h4, 1'b0, 2'h2}, '{DCS_DDR3, 2'h1, 3'h7, 1'b1, 2'h3},
		'{DCS_DDR4_X8, 2'h0, 3'h7, 1'b0, 2'h0}, '{DCS_DDR4_X8, 2'h1, 3'h0, 1'b1, 2'h1},
		'{DCS_DDR4_X8, 2'h2, 3'h5, 1'b0, 2'h2}, '{DCS_DDR4_X8, 2'h3, 3'h2, 1'b1, 2'h3},
		'{DCS_DDR4_X16, 2'h0, 3'h0, 1'b0, 2'h0}, '{DCS_DDR4_X16, 2'h2, 3'h1, 1'b1, 2'h1},
		'{DCS_DDR4_X16, 2'h1, 3'h6, 1'b0, 2'h2}, '{DCS_DDR4_X16, 2'h3, 3'h3, 1'b1, 2'h3},
		'{dcs_tech_t'(2'h3), 2'h0, 3'h5, 1'b0, 2'h2}}; // Spare code maps as DDR3

	always #25 mclk = ~mclk;

	dcs_scheduler dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cal_done(cal_done),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .cmd_valid(cmd_valid),
		.cmd(cmd), .wr_buf_req(wr_buf_req), .wr_buf_addr(wr_buf_addr),
		.wr_mover_take(wr_mover_take), .rd_buf_valid(rd_buf_valid),
		.rd_buf_addr(rd_buf_addr), .rd_mover_take(rd_mover_take));
	dcs_app_master app (.mclk(mclk), .cal_done(cal_done), .req_ready(req_ready),
		.wr_buf_req(wr_buf_req), .wr_buf_addr(wr_buf_addr), .rd_buf_valid(rd_buf_valid),
		.req_valid(req_valid), .req(req), .wr_data(wr_data), .rd_seen(rd_seen));

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : reg_write

	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
		@(posedge mclk);
	endtask : reg_read

	// Bounded wait for commands, then for their data strobes to drain
	task automatic wait_cmds(input int n);
		for (int i = 0; i < 300 && (cmdq.size() < n || rd_a.size() + wr_a.size() > 0); i++)
			@(posedge mclk);
		check("cmd_count", cmdq.size(), n);
	endtask : wait_cmds

	function automatic dcs_req_t mk(input logic w, input logic [1:0] g, input logic [2:0] b,
		input logic [5:0] a);
		mk = '{write: w, bg: g, ba: b, row: 16'h1234, col: 10'h3f8, buf_addr: a};
	endfunction : mk

	// Monitor at the falling edge, where registered outputs have settled
	always @(negedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			tally_and_finish();
		end
		check("wr_mover_take", wr_mover_take, wr_prev);
		check("rd_mover_take", rd_mover_take, rd_buf_valid);
		wr_prev = wr_buf_req;
		if (rd_buf_valid === 1'b1) begin
			check("rd_buf_addr", rd_buf_addr, rd_a.pop_front());
			check("rd_time", cyc, rd_t.pop_front());
		end
		if (wr_buf_req === 1'b1) begin
			check("wr_buf_addr", wr_buf_addr, wr_a.pop_front());
			check("wr_time", cyc, wr_t.pop_front());
		end
		if (cmd_valid === 1'b1) begin
			cmdq.push_back(cmd);
			cmd_cyc.push_back(cyc);
			if (cmd.req.write) begin
				wr_a.push_back(cmd.req.buf_addr);
				wr_t.push_back(cyc + DCS_WR_LAT_CYC - 1);
			end else begin
				rd_a.push_back(cmd.req.buf_addr);
				rd_t.push_back(cyc + DCS_RD_LAT_CYC - 1);
			end
		end
	end

	initial begin
		logic [31:0] d;
		int          n, g, mn;
		repeat (16) @(posedge mclk);
		check("ready_in_reset", req_ready, 1'b0);
		rst_b    <= 1'b1;
		cal_done <= 1'b1;
		reg_read(DCS_OFF_CTRL, d);
		check("ctrl_reset", d, 32'h0);
		reg_read(DCS_OFF_GAP, d);
		check("gap_reset", d, {24'h0, DCS_GAP_RST});
		reg_read(DCS_OFF_STATUS, d);
		check("free_reset", d, 32'h0000000f);
		reg_read(8'h30, d);
		check("unmapped", d, 32'h0);
		// Mapping table: every technology, every machine, reads on machines 0 and 2, writes on 1 and 3
		foreach (rows[i]) begin
			reg_write(DCS_OFF_CTRL, {29'h0, rows[i].tech, 1'b0});
			app.send(mk(rows[i].wr, rows[i].bg, rows[i].ba, 6'(i)), 1'b1);
			wait_cmds(i + 1);
			check("gm", cmdq[i].gm, rows[i].gm);
			check("req", {cmdq[i].req.write, cmdq[i].req.buf_addr}, {rows[i].wr, 6'(i)});
		end
		// Master counter settles one edge after the last return
		@(negedge mclk);
		check("rd_seen", rd_seen, 32'h7);
		// Read, write, read on three machines, both policies and two gaps
		for (int p = 0; p < 2; p++) begin
			g  = p ? 21 : 12;
			mn = (g + 3) / 4 + 1;
			reg_write(DCS_OFF_GAP, 32'(g));
			reg_write(DCS_OFF_CTRL, {31'h0, p[0]});
			n = cmdq.size();
			app.send(mk(1'b0, 2'h0, 3'h0, 6'h20), 1'b0);
			app.send(mk(1'b1, 2'h0, 3'h2, 6'h21), 1'b0);
			app.send(mk(1'b0, 2'h0, 3'h4, 6'h22), 1'b1);
			wait_cmds(n + 3);
			check("order_1", cmdq[n].req.buf_addr, 6'h20);
			check("order_2", cmdq[n + 1].req.buf_addr, p ? 6'h21 : 6'h22);
			check("rw_gap", cmd_cyc[n + 2 - p] - cmd_cyc[n + 1 - p] >= mn, 1'b1);
		end
		// Same machine: write then two reads keep their order
		reg_write(DCS_OFF_CTRL, 32'h0);
		n = cmdq.size();
		app.send(mk(1'b1, 2'h0, 3'h6, 6'h30), 1'b0);
		app.send(mk(1'b0, 2'h0, 3'h7, 6'h31), 1'b0);
		app.send(mk(1'b0, 2'h0, 3'h6, 6'h32), 1'b1);
		wait_cmds(n + 3);
		for (int k = 0; k < 3; k++)
			check("same_gm", cmdq[n + k].req.buf_addr, 6'h30 + 6'(k));
		// Two reads on neighbouring machines, then reset while a write is held
		app.send(mk(1'b0, 2'h0, 3'h0, 6'h3a), 1'b0);
		app.send(mk(1'b0, 2'h0, 3'h2, 6'h3c), 1'b1);
		wait_cmds(n + 5);
		check("rr_next", cmdq[n + 4].gm, 2'h1);
		reg_read(DCS_OFF_ISSUED, d);
		check("issued", d, cmdq.size());
		app.send(mk(1'b1, 2'h0, 3'h2, 6'h3b), 1'b1);
		rst_b <= 1'b0;
		@(posedge mclk);
		rd_a.delete();
		rd_t.delete();
		@(posedge mclk);
		rst_b <= 1'b1;
		reg_read(DCS_OFF_STATUS, d);
		check("free_after_reset", d, 32'h0000000f);
		check("no_cmd_after_reset", cmdq.size(), n + 5);
		tally_and_finish();
	end
endmodule : testbench
